//--- verilog/pom_pkg.sv
// package: constants and types shared by the output macrocell array
package pom_pkg;
   // array shape
   localparam int         NCELL        = 10;
   localparam int         TERMS_WIDE   = 10;
   localparam int         TERMS_NARROW = 8;
   localparam logic [9:0] WIDE_CELLS   = 10'h030;   // cells 4 and 5 own the long sum

   // register byte offsets
   localparam logic [31:0] MODE_CFG_OFFS  = 32'h0000_0000;
   localparam logic [31:0] OE_CFG_OFFS    = 32'h0000_0004;
   localparam logic [31:0] CELL_STAT_OFFS = 32'h0000_0008;

   // field positions
   localparam int FIRST_SEL_LSB  = 0;    // 1 = registered, 0 = combinatorial
   localparam int SECOND_SEL_LSB = 16;   // 1 = inverted, 0 = true
   localparam int STAT_FLOP_LSB  = 0;
   localparam int STAT_PIN_LSB   = 16;

   // reset values
   localparam logic [9:0]  FIRST_SEL_RST  = 10'h000;
   localparam logic [9:0]  SECOND_SEL_RST = 10'h000;
   localparam logic [19:0] OE_CFG_RST     = 20'h0_0000;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // combinatorial enable selection, two bits per cell
   typedef enum logic [1:0]
   {
      OE_OFF  = 2'h0,
      OE_ON   = 2'h1,
      OE_TERM = 2'h2,
      OE_ALT  = 2'h3
   } pom_oe_sel_t;
endpackage

//--- verilog/pom_cell_if.sv
// interface: configuration and terms to the cell logic, results back
`timescale 1ns/100ps
`default_nettype none
interface pom_cell_if;
   logic [9:0]       firstSel;    // per cell mode
   logic [9:0]       secondSel;   // per cell polarity
   logic [19:0]      oeSel;       // per cell enable choice
   logic [9:0][9:0]  logicTerms;  // product terms per cell
   logic [9:0]       oeTerms;     // enable product term per cell
   logic             clrTerm;     // shared clear term
   logic             setTerm;     // shared set term
   logic [9:0]       pinSync;     // synchronised pin levels
   logic [9:0]       sumVec;      // sum term per cell
   logic [9:0]       flopD;       // next stored value
   logic [9:0]       pinDrv;      // next pin drive level
   logic [9:0]       pinEn;       // next pin enable
   logic [9:0]       fbTrue;      // next feedback, true form

   modport top
   (
      output firstSel, secondSel, oeSel, logicTerms, oeTerms,
      output clrTerm, setTerm, pinSync,
      input  sumVec, flopD, pinDrv, pinEn, fbTrue
   );
   modport core
   (
      input  firstSel, secondSel, oeSel, logicTerms, oeTerms,
      input  clrTerm, setTerm, pinSync,
      output sumVec, flopD, pinDrv, pinEn, fbTrue
   );
endinterface
`default_nettype wire

//--- verilog/pom_cell_logic.sv
// module: combinational next-state logic of every output macrocell
`timescale 1ns/100ps
`default_nettype none
module pom_cell_logic
(
   // towards the top
   pom_cell_if.core cif
);
   // one slice per cell; the top registers everything produced here except sumVec
   for (genvar c = 0; c < pom_pkg::NCELL; c++)
   begin : g_cell
      // long or short sum, the unused terms are masked off
      localparam int         NTERM = pom_pkg::WIDE_CELLS[c] ? pom_pkg::TERMS_WIDE
                                                             : pom_pkg::TERMS_NARROW;
      localparam logic [9:0] TMASK = 10'((11'h001 << NTERM) - 11'h001);
      logic              isReg;   // registered mode selected
      logic              pinLvl;  // level seen on the pin side of the buffer
      pom_pkg::pom_oe_sel_t oeCode;

      assign isReg  = cif.firstSel[c];
      assign oeCode = pom_pkg::pom_oe_sel_t'(cif.oeSel[2*c +: 2]);

      // product terms summed into one gate
      assign cif.sumVec[c] = |(cif.logicTerms[c] & TMASK);

      // clear beats set, set beats the sum; both ignore polarity
      assign cif.flopD[c] = cif.clrTerm ? 1'b0
                          : cif.setTerm ? 1'b1
                          : cif.sumVec[c];

      // pin drive: stored value or raw sum, then the polarity stage
      assign cif.pinDrv[c] = (isReg ? cif.flopD[c] : cif.sumVec[c])
                             ^ cif.secondSel[c];

      // enable: registered cells always use their own term
      always_comb
      begin
         if (isReg)
         begin
            cif.pinEn[c] = cif.oeTerms[c];
         end
         else
         begin
            unique case (oeCode)
               pom_pkg::OE_OFF: cif.pinEn[c] = 1'b0;
               pom_pkg::OE_ON:  cif.pinEn[c] = 1'b1;
               pom_pkg::OE_TERM,
               pom_pkg::OE_ALT: cif.pinEn[c] = cif.oeTerms[c];
            endcase
         end
      end

      // pin side of the buffer: own drive when enabled, else the board
      assign pinLvl = cif.pinEn[c] ? cif.pinDrv[c] : cif.pinSync[c];

      // registered cells feed back the inverted store, not the pin
      assign cif.fbTrue[c] = isReg ? ~cif.flopD[c] : pinLvl;
   end
endmodule
`default_nettype wire

//--- verilog/pom_macrocell_array.sv
// module: output macrocell array with its AXI4-Lite configuration slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pom_macrocell_array
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // axi4-lite write address
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_awaddr,
   // axi4-lite write data
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   // axi4-lite write response
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   output logic [1:0]            s_axi_bresp,
   // axi4-lite read address
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   input  wire logic [31:0]      s_axi_araddr,
   // axi4-lite read data
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   // product terms from the and array
   input  wire logic [9:0][9:0]  logicTerms,
   input  wire logic [9:0]       oeTerms,
   input  wire logic             sharedAsyncClearTerm,
   input  wire logic             sharedSyncSetTerm,
   // cell pins
   input  wire logic [9:0]       cellPinIn,
   output logic [9:0]            cellPinOut,
   output logic [9:0]            cellPinOe,
   // feedback into the and array
   output logic [9:0]            fbTrue,
   output logic [9:0]            fbComp
);
   // whole state of the block
   typedef struct packed
   {
      logic [9:0]  pinMeta;    // first synchroniser stage
      logic [9:0]  pinSync;    // second synchroniser stage
      logic [9:0]  firstSel;   // mode select per cell
      logic [9:0]  secondSel;  // polarity select per cell
      logic [19:0] oeSel;      // enable choice per cell
      logic [9:0]  flop;       // macrocell stores
      logic [9:0]  pinOut;     // pin drive levels
      logic [9:0]  pinOe;      // pin enables
      logic [9:0]  fbTrue;     // feedback, true form
      logic [9:0]  fbComp;     // feedback, complement
      logic        awHeld;     // write address waiting
      logic [31:0] awAddr;
      logic        wHeld;      // write data waiting
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } pom_top_state_t;

   pom_top_state_t s_q;  // registered state
   pom_top_state_t s_d;  // next state

   pom_cell_if cif ();

   // cell logic works only on inputs and configuration
   pom_cell_logic u_cells
   (
      .cif (cif.core)
   );

   // terms come from same-clock logic, so no synchroniser on them
   assign cif.firstSel   = s_q.firstSel;
   assign cif.secondSel  = s_q.secondSel;
   assign cif.oeSel      = s_q.oeSel;
   assign cif.logicTerms = logicTerms;
   assign cif.oeTerms    = oeTerms;
   assign cif.clrTerm    = sharedAsyncClearTerm;
   assign cif.setTerm    = sharedSyncSetTerm;
   assign cif.pinSync    = s_q.pinSync;

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldW,
                                              input logic [31:0] newW,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = oldW;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = newW[8*b +: 8];
         end
      end
      return res;
   endfunction

   // next state: cells, synchroniser and both bus channels
   always_comb
   begin
      logic [31:0] modeWord;
      logic [31:0] oeWord;
      logic [31:0] statWord;
      logic [31:0] merged;
      modeWord = '0;
      oeWord   = '0;
      statWord = '0;
      merged   = '0;
      s_d      = s_q;
      // readable words built from the live state
      modeWord[pom_pkg::FIRST_SEL_LSB +: 10]  = s_q.firstSel;
      modeWord[pom_pkg::SECOND_SEL_LSB +: 10] = s_q.secondSel;
      oeWord[19:0]                            = s_q.oeSel;
      statWord[pom_pkg::STAT_FLOP_LSB +: 10]  = s_q.flop;
      for (int c = 0; c < pom_pkg::NCELL; c++)
      begin
         statWord[pom_pkg::STAT_PIN_LSB + c] = s_q.pinOe[c] ? s_q.pinOut[c]
                                                              : s_q.pinSync[c];
      end
      // pins pass two flip-flops before any logic sees them
      s_d.pinMeta = cellPinIn;
      s_d.pinSync = s_q.pinMeta;
      // cells update on every rising edge
      s_d.flop   = cif.flopD;
      s_d.pinOut = cif.pinDrv;
      s_d.pinOe  = cif.pinEn;
      s_d.fbTrue = cif.fbTrue;
      s_d.fbComp = ~cif.fbTrue;
      // write address and data are taken in either order
      if (s_q.awready && s_axi_awvalid)
      begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_q.wready && s_axi_wvalid)
      begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      // both halves present: perform the write and answer
      if (s_q.awHeld && s_q.wHeld && !s_q.bvalid)
      begin
         s_d.awHeld = 1'b0;
         s_d.wHeld  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = pom_pkg::RESP_OKAY;
         case (s_q.awAddr)
            pom_pkg::MODE_CFG_OFFS:
            begin
               merged        = mergeBytes(modeWord, s_q.wData, s_q.wStrb);
               s_d.firstSel  = merged[pom_pkg::FIRST_SEL_LSB +: 10];
               s_d.secondSel = merged[pom_pkg::SECOND_SEL_LSB +: 10];
            end
            pom_pkg::OE_CFG_OFFS:
            begin
               merged    = mergeBytes(oeWord, s_q.wData, s_q.wStrb);
               s_d.oeSel = merged[19:0];
            end
            // status is read-only; a write is accepted and dropped
            pom_pkg::CELL_STAT_OFFS:
            begin
               s_d.bresp = pom_pkg::RESP_OKAY;
            end
            default:
            begin
               s_d.bresp = pom_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_q.bvalid && s_axi_bready)
      begin
         s_d.bvalid = 1'b0;
      end
      // a held half blocks its channel until the write completes
      s_d.awready = !s_d.awHeld;
      s_d.wready  = !s_d.wHeld;
      // read: one outstanding, answered on the next cycle
      if (s_q.arready && s_axi_arvalid)
      begin
         s_d.arready = 1'b0;
         s_d.rvalid  = 1'b1;
         s_d.rresp   = pom_pkg::RESP_OKAY;
         case (s_axi_araddr)
            pom_pkg::MODE_CFG_OFFS:  s_d.rdata = modeWord;
            pom_pkg::OE_CFG_OFFS:    s_d.rdata = oeWord;
            pom_pkg::CELL_STAT_OFFS: s_d.rdata = statWord;
            default:
            begin
               s_d.rdata = '0;
               s_d.rresp = pom_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s_q.rvalid && s_axi_rready)
      begin
         s_d.rvalid  = 1'b0;
         s_d.arready = 1'b1;
      end
      // synchronous reset wins over everything
      if (sys_rst)
      begin
         s_d           = '0;
         s_d.firstSel  = pom_pkg::FIRST_SEL_RST;
         s_d.secondSel = pom_pkg::SECOND_SEL_RST;
         s_d.oeSel     = pom_pkg::OE_CFG_RST;
         s_d.awready   = 1'b1;
         s_d.wready    = 1'b1;
         s_d.arready   = 1'b1;
      end
   end

   // single register stage for the whole block
   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   // every output straight from a flip-flop
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rdata   = s_q.rdata;
   assign s_axi_rresp   = s_q.rresp;
   assign cellPinOut    = s_q.pinOut;
   assign cellPinOe     = s_q.pinOe;
   assign fbTrue        = s_q.fbTrue;
   assign fbComp        = s_q.fbComp;

   // checks on the cell behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // the last reset edge still starts an attempt, so some antecedents exclude it

   sequence clearHeld;
      sharedAsyncClearTerm [*2];
   endsequence

   clear_hold_a: assert property (clearHeld |-> s_q.flop == 10'h000)
      else $error("stores not held at zero during clear");
   set_load_a: assert property
      (!sys_rst && sharedSyncSetTerm && !sharedAsyncClearTerm |=> s_q.flop == 10'h3ff)
      else $error("set term did not load ones");
   clear_wins_a: assert property
      (sharedAsyncClearTerm && sharedSyncSetTerm |=> s_q.flop == 10'h000)
      else $error("set beat clear");
   reg_pin_a: assert property
      (!sys_rst |=> ((s_q.pinOut ^ $past(s_q.secondSel) ^ s_q.flop)
                 & $past(s_q.firstSel)) == 10'h000)
      else $error("registered pin differs from store");
   comb_pin_a: assert property
      (!sys_rst |=> ((s_q.pinOut ^ $past(s_q.secondSel) ^ $past(cif.sumVec))
                 & ~$past(s_q.firstSel)) == 10'h000)
      else $error("combinatorial pin differs from sum");

   // per-cell checks
   for (genvar c = 0; c < pom_pkg::NCELL; c++)
   begin : g_chk
      oe_term_a: assert property
         (s_q.firstSel[c] |=> s_q.pinOe[c] == $past(oeTerms[c]))
         else $error("registered enable not from its term");
      oe_off_a: assert property
         (!s_q.firstSel[c] && s_q.oeSel[2*c +: 2] == pom_pkg::OE_OFF
          |=> !s_q.pinOe[c] && s_q.fbTrue[c] == $past(s_q.pinSync[c]))
         else $error("input-only cell drove or missed the pin");
      oe_on_a: assert property
         (!s_q.firstSel[c] && s_q.oeSel[2*c +: 2] == pom_pkg::OE_ON
          |=> s_q.pinOe[c] && s_q.fbTrue[c] == s_q.pinOut[c])
         else $error("output-only cell not driving");
      reg_fb_a: assert property
         (s_q.firstSel[c] |=> s_q.fbTrue[c] == !s_q.flop[c]
                              && s_q.fbComp[c] == s_q.flop[c])
         else $error("registered feedback not from inverted store");
      sum_len_a: assert property
         (!s_q.firstSel[c] && logicTerms[c][9:8] != 2'h0
          && logicTerms[c][7:0] == 8'h00
          |=> s_q.pinOut[c] == ($past(s_q.secondSel[c]) ^ pom_pkg::WIDE_CELLS[c]))
         else $error("upper terms handled wrongly for sum length");
   end
endmodule
`default_nettype wire

//--- testbench/pom_board_model.sv
// board model: product term source and resolved pin levels with pull-ups
`timescale 1ns/100ps
`default_nettype none
module pom_board_model
(
   // term pattern chosen by the bench
   input  wire logic [9:0]  termSel,
   input  wire logic [3:0]  termBit,
   // pin drivers on both sides
   input  wire logic [9:0]  dutOut,
   input  wire logic [9:0]  dutOe,
   input  wire logic [9:0]  boardEn,
   input  wire logic [9:0]  boardVal,
   // towards the block
   output logic [9:0][9:0]  terms,
   output logic [9:0]       pinLvl
);
   // one term bit per selected cell; bits 9:8 only count in the wide cells
   always_comb
   begin
      for (int c = 0; c < 10; c++)
      begin
         terms[c] = termSel[c] ? (10'h001 << termBit) : 10'h000;
      end
   end
   // undriven pins float high through the pull-ups; the block wins a clash,
   // so rows that drive both sides only test the block's own level
   assign pinLvl = (dutOe & dutOut) | (~dutOe & ~boardEn) | (~dutOe & boardEn & boardVal);
endmodule
`default_nettype wire

//--- testbench/tb.sv
// testbench: row table for cell behaviour, then bus, set/clear and mid-run reset cases
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) checkCount++; if ((s) !== (e)) begin nFail++; $display("MISMATCH %s expected %h seen %h", nm, e, s); end
module tb;
   // one row: configuration, terms and board drive
   typedef struct packed
   {
      logic [9:0]  mode;
      logic [9:0]  pol;
      logic [19:0] oe;
      logic [9:0]  tv;
      logic [3:0]  k;
      logic [9:0]  oeT;
      logic [9:0]  bEn;
      logic [9:0]  bVal;
   } pom_row_t;
   pom_row_t rows [6] = '{
      '{10'h000, 10'h0AA, 20'h5_5555, 10'h3FF, 4'h0, 10'h000, 10'h000, 10'h000},
      '{10'h000, 10'h000, 20'h5_5555, 10'h3FF, 4'h9, 10'h000, 10'h000, 10'h000},
      '{10'h000, 10'h155, 20'h0_0000, 10'h3FF, 4'h7, 10'h3FF, 10'h3FF, 10'h2A5},
      '{10'h000, 10'h000, 20'hF_AAAA, 10'h2DB, 4'h5, 10'h0F0, 10'h30F, 10'h155},
      '{10'h3FF, 10'h1F0, 20'h0_0000, 10'h2CC, 4'h3, 10'h3C3, 10'h03C, 10'h3FF},
      '{10'h155, 10'h0F0, 20'hE_4E41, 10'h1B6, 4'h8, 10'h2AA, 10'h155, 10'h0C3}};
   // clock, reset and bus
   logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   // terms and pins
   logic [9:0]      termSel, oeTerms, boardEn, boardVal, pinLvl;
   logic [9:0]      cellPinOut, cellPinOe, fbTrue, fbComp;
   logic [3:0]      termBit;
   logic [9:0][9:0] terms;
   logic            clrTerm, setTerm;
   int              nFail = 0;
   int              checkCount = 0;

   pom_board_model board (.termSel(termSel), .termBit(termBit), .dutOut(cellPinOut),
      .dutOe(cellPinOe), .boardEn(boardEn), .boardVal(boardVal), .terms(terms), .pinLvl(pinLvl));
   pom_macrocell_array dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .logicTerms(terms),
      .oeTerms(oeTerms), .sharedAsyncClearTerm(clrTerm), .sharedSyncSetTerm(setTerm),
      .cellPinIn(pinLvl), .cellPinOut(cellPinOut), .cellPinOe(cellPinOe), .fbTrue(fbTrue),
      .fbComp(fbComp));

   // expected steady outputs of one row, with clear and set idle
   function automatic void model(input pom_row_t r, output logic [9:0] out, oe, fb, sum, lvl);
      for (int c = 0; c < 10; c++)
      begin
         sum[c] = r.tv[c] & (r.k < 4'h8 | pom_pkg::WIDE_CELLS[c]);
         out[c] = sum[c] ^ r.pol[c];
         oe[c] = (r.mode[c] | r.oe[2*c+1]) ? r.oeT[c] : r.oe[2*c];
         lvl[c] = oe[c] ? out[c] : (~r.bEn[c] | r.bVal[c]);
         fb[c] = r.mode[c] ? ~sum[c] : lvl[c];
      end
   endfunction

   // write: address and data offered together, each dropped once taken
   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
      @(posedge clk);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr  <= a;
      s_axi_wvalid  <= 1'h1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_bready  <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready === 1'h1)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1)
            s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   // read: address held until taken, rready held until rvalid is seen
   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr  <= a;
      s_axi_rready  <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready === 1'h1)
            s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   // single place where the run ends
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", checkCount, nFail);
      if (nFail == 0 && checkCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // 125 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end

   // watchdog: the whole sequence needs well under 2000 cycles
   initial
   begin
      #100_000;
      nFail++;
      giveVerdict();
   end

   // main sequence
   initial
   begin
      logic [1:0]  resp;
      logic [31:0] rd;
      logic [9:0]  eOut, eOe, eFb, eSum, eLvl;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
      {termSel, termBit, oeTerms, boardEn, boardVal, clrTerm, setTerm} = 46'h0;
      sys_rst = 1'h1;
      repeat (10) @(posedge clk);
      #1;
      `CHK("reset oe", 10'h000, cellPinOe)
      `CHK("reset ready", 2'h3, {s_axi_awready, s_axi_arready})
      `CHK("reset valid", 2'h0, {s_axi_bvalid, s_axi_rvalid})
      @(posedge clk);
      sys_rst <= 1'h0;
      axr(pom_pkg::MODE_CFG_OFFS, rd, resp);
      `CHK("mode reset", 32'h0000_0000, rd)
      axr(pom_pkg::OE_CFG_OFFS, rd, resp);
      `CHK("oe cfg reset", 32'h0000_0000, rd)
      // ordinary cases, one row at a time
      foreach (rows[i])
      begin
         axw(pom_pkg::MODE_CFG_OFFS, {6'h00, rows[i].pol, 6'h00, rows[i].mode}, 4'hF, resp);
         axw(pom_pkg::OE_CFG_OFFS, {12'h000, rows[i].oe}, 4'hF, resp);
         termSel  <= rows[i].tv;
         termBit  <= rows[i].k;
         oeTerms  <= rows[i].oeT;
         boardEn  <= rows[i].bEn;
         boardVal <= rows[i].bVal;
         repeat (6) @(posedge clk);
         #1;
         model(rows[i], eOut, eOe, eFb, eSum, eLvl);
         `CHK("pin oe", eOe, cellPinOe)
         `CHK("pin out", eOut & eOe, cellPinOut & eOe)
         `CHK("fb true", eFb, fbTrue)
         `CHK("fb comp", ~eFb, fbComp)
         axr(pom_pkg::CELL_STAT_OFFS, rd, resp);
         `CHK("cell stat", {6'h00, eLvl, 6'h00, eSum}, rd)
      end
      // bus corner cases: unmapped place, read-only place, byte strobes
      axr(32'h0000_000C, rd, resp);
      `CHK("bad read", 34'h2_0000_0000, {resp, rd})
      axw(32'h0000_000C, 32'hFFFF_FFFF, 4'hF, resp);
      `CHK("bad write", pom_pkg::RESP_SLVERR, resp)
      axw(pom_pkg::CELL_STAT_OFFS, 32'hFFFF_FFFF, 4'hF, resp);
      `CHK("stat write", pom_pkg::RESP_OKAY, resp)
      axw(pom_pkg::MODE_CFG_OFFS, 32'h0000_0000, 4'hF, resp);
      axw(pom_pkg::MODE_CFG_OFFS, 32'hFFFF_FFFF, 4'h4, resp);
      axr(pom_pkg::MODE_CFG_OFFS, rd, resp);
      `CHK("strobe", 32'h00FF_0000, rd)
      // set and clear on all registered cells, inverted polarity on 7:4
      axw(pom_pkg::MODE_CFG_OFFS, 32'h00F0_03FF, 4'hF, resp);
      termSel <= 10'h000;
      oeTerms <= 10'h3FF;
      repeat (4) @(posedge clk);
      setTerm <= 1'h1;
      @(posedge clk);
      setTerm <= 1'h0;
      #1;
      `CHK("set edge", 10'h30F, cellPinOut)
      @(posedge clk);
      // stimulus moves on the edge; term bit 0 so every cell sums to one
      setTerm <= 1'h1;
      clrTerm <= 1'h1;
      termSel <= 10'h3FF;
      termBit <= 4'h0;
      #1;
      `CHK("set gone", 10'h0F0, cellPinOut)
      repeat (3) @(posedge clk);
      setTerm <= 1'h0;
      #1;
      `CHK("clear wins", 10'h0F0, cellPinOut)
      repeat (3) @(posedge clk);
      clrTerm <= 1'h0;
      #1;
      `CHK("clear holds", 10'h0F0, cellPinOut)
      repeat (3) @(posedge clk);
      #1;
      `CHK("clear off", 10'h30F, cellPinOut)
      // reset in mid-run: outputs, bus and configuration start over
      @(posedge clk);
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      #1;
      `CHK("rerun pins", 30'h0000_0000, {cellPinOut, cellPinOe, fbTrue})
      `CHK("rerun bus", 4'hC, {s_axi_awready, s_axi_arready, s_axi_bvalid, s_axi_rvalid})
      axr(pom_pkg::MODE_CFG_OFFS, rd, resp);
      `CHK("rerun mode", 32'h0000_0000, rd)
      giveVerdict();
   end
endmodule
`default_nettype wire
